// file: rtl/rctmr_pkg.sv
// package: register map, field positions and timing constants of the reload/capture timer
package rctmr_pkg;
	localparam logic [7:0] OFS_CONTROL = 8'h00;
	localparam logic [7:0] OFS_MODE = 8'h04;
	localparam logic [7:0] OFS_RELOAD = 8'h08;
	localparam logic [7:0] OFS_COUNT = 8'h10;
	localparam logic [7:0] OFS_ICLR = 8'h18;
	localparam logic [7:0] OFS_IEN = 8'h1c;
	// mode register fields
	localparam int MOD_START_EDGE = 7;
	localparam int MOD_HW_START = 6;
	localparam int MOD_TRIG_EDGE = 5;
	localparam int MOD_PRESC_EN = 4;
	localparam int MOD_RATIO_LO = 1;
	localparam int MOD_UPDOWN = 0;
	// control register fields
	localparam int CON_OVF = 7;
	localparam int CON_EXT = 6;
	localparam int CON_EXT_EN = 3;
	localparam int CON_RUN = 2;
	localparam int CON_CNT_SEL = 1;
	localparam int CON_CAP_SEL = 0;
	localparam logic [7:0] CON_SW_MASK = 8'h0f;
	// interrupt clear / enable fields
	localparam int ICLR_OVF = 7;
	localparam int ICLR_EXT = 6;
	localparam int IEN_OVF = 1;
	localparam int IEN_EXT = 0;
	localparam logic [7:0] MODE_RESET = 8'h00;
	localparam logic [7:0] CON_RESET = 8'h00;
	localparam logic [15:0] CNT_RESET = 16'h0000;
	localparam logic [15:0] CNT_MAX = 16'hffff;
	localparam logic [15:0] CNT_MIN = 16'h0000;
	// fixed divider: system clock / 12 when the prescaler is off
	localparam logic [3:0] FIXED_DIV = 4'hc;
	localparam logic [3:0] FIXED_DIV_LAST = 4'hb;
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [2:0] HSIZE_WORD = 3'h2;

	typedef struct packed {
		logic sel;
		logic write;
		logic [7:0] addr;
	} rctmr_ahb_s;

	typedef struct packed {
		rctmr_ahb_s ap;
		logic [7:0] mode;
		logic [3:0] con_sw;
		logic ovf;
		logic ext;
		logic [1:0] ien;
		logic [15:0] reload;
		logic [15:0] count;
		logic [3:0] fixdiv;
		logic [6:0] presc;
		logic trig_prev;
		logic cpin_prev;
		logic adc_trig;
		logic irq;
	} rctmr_state_s;
endpackage

// file: rtl/rctmr_top.sv
// reload/capture 16-bit timer with AHB-Lite register slave
`timescale 1ns/100ps
module rctmr_top (
	input wire logic clk,
	input wire logic rst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic trigger_pin,
	input wire logic count_pin,
	input wire logic debug_suspend,
	input wire logic debug_suspend_enable,
	output logic irq,
	output logic adc_trigger_out
);
	rctmr_pkg::rctmr_state_s s_q, s_d;

	// ratio code to terminal prescale count (2**code - 1)
	function automatic logic [6:0] presc_last(input logic [2:0] code);
		presc_last = 7'((8'h01 << code) - 8'h01);
	endfunction

	// edge match helper: rise=1 selects rising edge
	function automatic logic edge_hit(input logic prev, input logic cur, input logic rise);
		edge_hit = rise ? (!prev && cur) : (prev && !cur);
	endfunction

	logic ap_valid;
	logic wr_en;
	logic tick_int;
	logic tick;
	logic frozen;
	logic cnt_edge;
	logic trig_evt;
	logic start_evt;
	logic cap_mode;
	logic updown;
	logic run;
	logic ovf_set;
	logic ext_set;
	logic ext_toggle;
	logic [15:0] cnt_next;
	logic [7:0] con_rd;

	// zero-wait slave; only whole-word transfers are taken
	assign ap_valid = hsel && hready && htrans == rctmr_pkg::HTRANS_NONSEQ
		&& hsize == rctmr_pkg::HSIZE_WORD;
	assign wr_en = s_q.ap.sel && s_q.ap.write;
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign irq = s_q.irq;
	assign adc_trigger_out = s_q.adc_trig;

	assign cap_mode = s_q.con_sw[rctmr_pkg::CON_CAP_SEL];
	assign updown = s_q.mode[rctmr_pkg::MOD_UPDOWN] && !cap_mode;
	assign run = s_q.con_sw[rctmr_pkg::CON_RUN];
	assign frozen = debug_suspend && debug_suspend_enable;

	// tick sources; fixed /12 only when the prescaler is off
	always_comb begin
		if (s_q.mode[rctmr_pkg::MOD_PRESC_EN]) begin
			tick_int = s_q.presc == presc_last(s_q.mode[3:1]);
		end else begin
			tick_int = s_q.fixdiv == rctmr_pkg::FIXED_DIV_LAST;
		end
	end
	// count pin counts 1-to-0 transitions sampled on two clocks
	assign cnt_edge = s_q.cpin_prev && !count_pin;
	assign tick = s_q.con_sw[rctmr_pkg::CON_CNT_SEL] ? cnt_edge : tick_int;

	assign trig_evt = edge_hit(s_q.trig_prev, trigger_pin, s_q.mode[rctmr_pkg::MOD_TRIG_EDGE])
		&& s_q.con_sw[rctmr_pkg::CON_EXT_EN];
	assign start_evt = s_q.mode[rctmr_pkg::MOD_HW_START] && !run
		&& edge_hit(s_q.trig_prev, trigger_pin, s_q.mode[rctmr_pkg::MOD_START_EDGE]);

	// next count value and overflow detection
	always_comb begin
		cnt_next = s_q.count;
		ovf_set = 1'b0;
		ext_toggle = 1'b0;
		if (run && tick && !frozen) begin
			if (updown && !trigger_pin) begin
				if (s_q.count == s_q.reload) begin
					cnt_next = rctmr_pkg::CNT_MAX;
					ovf_set = 1'b1;
					ext_toggle = 1'b1;
				end else begin
					cnt_next = s_q.count - 16'h0001;
				end
			end else if (s_q.count == rctmr_pkg::CNT_MAX) begin
				ovf_set = 1'b1;
				ext_toggle = updown;
				cnt_next = cap_mode ? rctmr_pkg::CNT_MIN : s_q.reload;
			end else begin
				cnt_next = s_q.count + 16'h0001;
			end
		end
	end
	// in up/down mode the external flag toggles on wrap rather than on edges
	assign ext_set = trig_evt && !updown;

	// read mux; reserved bits stay zero
	always_comb begin
		con_rd = 8'h00;
		con_rd[3:0] = s_q.con_sw;
		con_rd[rctmr_pkg::CON_OVF] = s_q.ovf;
		con_rd[rctmr_pkg::CON_EXT] = s_q.ext;
		hrdata = 32'h0000_0000;
		if (s_q.ap.sel && !s_q.ap.write) begin
			unique case (s_q.ap.addr)
				rctmr_pkg::OFS_CONTROL: hrdata = {24'h00_0000, con_rd};
				rctmr_pkg::OFS_MODE: hrdata = {24'h00_0000, s_q.mode};
				rctmr_pkg::OFS_RELOAD: hrdata = {16'h0000, s_q.reload};
				rctmr_pkg::OFS_COUNT: hrdata = {16'h0000, s_q.count};
				rctmr_pkg::OFS_IEN: hrdata = {30'h0000_0000, s_q.ien};
				default: hrdata = 32'h0000_0000;
			endcase
		end
	end

	// whole next state
	always_comb begin
		s_d = s_q;
		s_d.ap.sel = ap_valid;
		s_d.ap.write = hwrite;
		s_d.ap.addr = haddr[7:0];
		s_d.trig_prev = trigger_pin;
		s_d.cpin_prev = count_pin;
		// dividers run always; suspend only freezes the count
		s_d.fixdiv = (s_q.fixdiv == rctmr_pkg::FIXED_DIV_LAST) ? 4'h0 : s_q.fixdiv + 4'h1;
		s_d.presc = (s_q.presc >= presc_last(s_q.mode[3:1])) ? 7'h00 : s_q.presc + 7'h01;
		s_d.adc_trig = !s_q.con_sw[rctmr_pkg::CON_CNT_SEL] && run && ovf_set;
		if (start_evt) begin
			s_d.con_sw[rctmr_pkg::CON_RUN] = 1'b1;
		end
		// hardware counting, then trigger reload or capture
		s_d.count = cnt_next;
		if (trig_evt && !updown) begin
			if (cap_mode) begin
				s_d.reload = cnt_next;
			end else begin
				s_d.count = s_q.reload;
			end
		end
		// software writes win over hardware updates
		if (wr_en) begin
			unique case (s_q.ap.addr)
				rctmr_pkg::OFS_CONTROL: s_d.con_sw = hwdata[3:0] & rctmr_pkg::CON_SW_MASK[3:0];
				rctmr_pkg::OFS_MODE: s_d.mode = hwdata[7:0];
				rctmr_pkg::OFS_RELOAD: s_d.reload = hwdata[15:0];
				rctmr_pkg::OFS_COUNT: s_d.count = hwdata[15:0];
				rctmr_pkg::OFS_IEN: s_d.ien = hwdata[1:0];
				default: s_d.ien = s_q.ien;
			endcase
		end
		// flags: a hardware set wins over a clear in the same cycle
		if (wr_en && s_q.ap.addr == rctmr_pkg::OFS_ICLR && hwdata[rctmr_pkg::ICLR_OVF]) begin
			s_d.ovf = 1'b0;
		end
		if (wr_en && s_q.ap.addr == rctmr_pkg::OFS_ICLR && hwdata[rctmr_pkg::ICLR_EXT]) begin
			s_d.ext = 1'b0;
		end
		if (ovf_set) begin
			s_d.ovf = 1'b1;
		end
		if (ext_set) begin
			s_d.ext = 1'b1;
		end else if (ext_toggle) begin
			s_d.ext = !s_q.ext;
		end
		s_d.irq = (s_q.ovf && s_q.ien[rctmr_pkg::IEN_OVF])
			|| (s_q.ext && s_q.ien[rctmr_pkg::IEN_EXT] && !updown);
	end

	// single state register, synchronous reset
	always_ff @(posedge clk) begin
		if (rst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	property p_ovf_sets;
		@(posedge clk) disable iff (rst) ovf_set |=> s_q.ovf;
	endproperty
	a_ovf_sets: assert property (p_ovf_sets) else $error("overflow flag not set");

	property p_ovf_clear;
		@(posedge clk) disable iff (rst)
		wr_en && s_q.ap.addr == rctmr_pkg::OFS_ICLR && hwdata[7] && !ovf_set |=> !s_q.ovf;
	endproperty
	a_ovf_clear: assert property (p_ovf_clear) else $error("overflow flag not cleared");

	property p_ext_clear;
		@(posedge clk) disable iff (rst)
		wr_en && s_q.ap.addr == rctmr_pkg::OFS_ICLR && hwdata[6] && !ext_set && !ext_toggle
		|=> !s_q.ext;
	endproperty
	a_ext_clear: assert property (p_ext_clear) else $error("external flag not cleared");

	property p_freeze;
		@(posedge clk) disable iff (rst) frozen && !wr_en && !trig_evt |=> $stable(s_q.count);
	endproperty
	a_freeze: assert property (p_freeze) else $error("count moved while suspended");

	property p_adc;
		@(posedge clk) disable iff (rst)
		s_q.adc_trig |-> !$past(s_q.con_sw[rctmr_pkg::CON_CNT_SEL]);
	endproperty
	a_adc: assert property (p_adc) else $error("adc trigger in counter mode");

	property p_underflow;
		@(posedge clk) disable iff (rst)
		run && tick && !frozen && updown && !trigger_pin && s_q.count == s_q.reload && !wr_en
		|=> s_q.count == rctmr_pkg::CNT_MAX && s_q.ovf;
	endproperty
	a_underflow: assert property (p_underflow) else $error("underflow reload wrong");

	property p_cap_wrap;
		@(posedge clk) disable iff (rst)
		run && tick && !frozen && cap_mode && s_q.count == rctmr_pkg::CNT_MAX && !wr_en
		|=> s_q.count == rctmr_pkg::CNT_MIN;
	endproperty
	a_cap_wrap: assert property (p_cap_wrap) else $error("capture wrap not zero");

	property p_hw_start;
		@(posedge clk) disable iff (rst) start_evt && !wr_en |=> s_q.con_sw[2];
	endproperty
	a_hw_start: assert property (p_hw_start) else $error("hardware start missed");

	property p_cnt_write;
		@(posedge clk) disable iff (rst)
		wr_en && s_q.ap.addr == rctmr_pkg::OFS_COUNT |=> s_q.count == $past(hwdata[15:0]);
	endproperty
	a_cnt_write: assert property (p_cnt_write) else $error("count write lost");

	property p_irq_sup;
		@(posedge clk) disable iff (rst)
		updown && !s_q.ovf ##1 updown |-> !s_q.irq || s_q.ovf || $past(s_q.ovf);
	endproperty
	a_irq_sup: assert property (p_irq_sup) else $error("external irq in up/down mode");

	// flag paths: an external set event raises its flag; an overflow flag rise needs its own event
	property p_ext_sets;
		@(posedge clk) disable iff (rst) ext_set |=> s_q.ext;
	endproperty
	a_ext_sets: assert property (p_ext_sets) else $error("external flag not set");

	property p_ovf_cause;
		@(posedge clk) disable iff (rst) !ovf_set |=> !$rose(s_q.ovf);
	endproperty
	a_ovf_cause: assert property (p_ovf_cause) else $error("overflow flag rose without wrap");

	// with events off only an up/down wrap may raise the external flag
	property p_ext_gate;
		@(posedge clk) disable iff (rst)
		!s_q.con_sw[rctmr_pkg::CON_EXT_EN] && !ext_toggle |=> !$rose(s_q.ext);
	endproperty
	a_ext_gate: assert property (p_ext_gate) else $error("external flag rose, events off");

	// interrupt follows an enabled flag one cycle later; the external flag only outside up/down mode
	property p_irq_ovf;
		@(posedge clk) disable iff (rst) s_q.ovf && s_q.ien[rctmr_pkg::IEN_OVF] |=> irq;
	endproperty
	a_irq_ovf: assert property (p_irq_ovf) else $error("overflow irq missing");

	property p_irq_ext;
		@(posedge clk) disable iff (rst)
		s_q.ext && s_q.ien[rctmr_pkg::IEN_EXT] && !updown |=> irq;
	endproperty
	a_irq_ext: assert property (p_irq_ext) else $error("external irq missing");

	// plain counting steps; writes and trigger reloads are left out
	property p_up_step;
		@(posedge clk) disable iff (rst)
		run && tick && !frozen && !(updown && !trigger_pin)
		&& s_q.count != rctmr_pkg::CNT_MAX && !wr_en && !trig_evt
		|=> s_q.count == $past(s_q.count) + 16'h0001;
	endproperty
	a_up_step: assert property (p_up_step) else $error("up count step wrong");

	property p_down_step;
		@(posedge clk) disable iff (rst)
		run && tick && !frozen && updown && !trigger_pin && s_q.count != s_q.reload && !wr_en
		|=> s_q.count == $past(s_q.count) - 16'h0001;
	endproperty
	a_down_step: assert property (p_down_step) else $error("down count step wrong");

	property p_ovf_reload;
		@(posedge clk) disable iff (rst)
		run && tick && !frozen && !cap_mode && !(updown && !trigger_pin)
		&& s_q.count == rctmr_pkg::CNT_MAX && !wr_en && !trig_evt
		|=> s_q.count == $past(s_q.reload);
	endproperty
	a_ovf_reload: assert property (p_ovf_reload) else $error("overflow reload wrong");

	// trigger reload replaces the count even when a tick falls in the same cycle
	property p_trig_reload;
		@(posedge clk) disable iff (rst)
		trig_evt && !updown && !cap_mode && !wr_en |=> s_q.count == $past(s_q.reload);
	endproperty
	a_trig_reload: assert property (p_trig_reload) else $error("trigger reload lost");

	property p_capture;
		@(posedge clk) disable iff (rst)
		trig_evt && !updown && cap_mode && !wr_en |=> s_q.reload == $past(cnt_next);
	endproperty
	a_capture: assert property (p_capture) else $error("capture value wrong");

	property p_stopped;
		@(posedge clk) disable iff (rst) !run && !wr_en && !trig_evt |=> $stable(s_q.count);
	endproperty
	a_stopped: assert property (p_stopped) else $error("count moved while stopped");

	property p_hw_start_off;
		@(posedge clk) disable iff (rst)
		!s_q.mode[rctmr_pkg::MOD_HW_START] && !run && !wr_en
		|=> !s_q.con_sw[rctmr_pkg::CON_RUN];
	endproperty
	a_hw_start_off: assert property (p_hw_start_off) else $error("run set by pin");

	// edge selection of start and event triggers
	property p_start_edge;
		@(posedge clk) disable iff (rst)
		start_evt |-> trigger_pin == s_q.mode[rctmr_pkg::MOD_START_EDGE];
	endproperty
	a_start_edge: assert property (p_start_edge) else $error("start on wrong edge");

	property p_trig_edge;
		@(posedge clk) disable iff (rst)
		trig_evt |-> trigger_pin == s_q.mode[rctmr_pkg::MOD_TRIG_EDGE];
	endproperty
	a_trig_edge: assert property (p_trig_edge) else $error("event on wrong edge");

	// fixed path: one tick, eleven quiet cycles, next tick; a mode change excuses it
	property p_fixed_period;
		@(posedge clk) disable iff (rst)
		!s_q.mode[rctmr_pkg::MOD_PRESC_EN] && tick_int
		|=> (!tick_int || s_q.mode[rctmr_pkg::MOD_PRESC_EN])
		##11 (tick_int || s_q.mode[rctmr_pkg::MOD_PRESC_EN]);
	endproperty
	a_fixed_period: assert property (p_fixed_period) else $error("fixed divider period");

	property p_cnt_src;
		@(posedge clk) disable iff (rst)
		s_q.con_sw[rctmr_pkg::CON_CNT_SEL] && !cnt_edge |-> !tick;
	endproperty
	a_cnt_src: assert property (p_cnt_src) else $error("tick without count pin edge");

	property p_adc_fire;
		@(posedge clk) disable iff (rst)
		ovf_set && !s_q.con_sw[rctmr_pkg::CON_CNT_SEL] |=> s_q.adc_trig;
	endproperty
	a_adc_fire: assert property (p_adc_fire) else $error("adc trigger missing");
endmodule // rctmr_top

// file: verif/rctmr_pins.sv
// pin-side partner: drives the trigger level and bursts of count-pin pulses
`timescale 1ns/100ps
module rctmr_pins #(
	parameter int HALF = 2
) (
	input wire logic clk,
	input wire logic trig_lvl,
	input wire logic go,
	input wire logic [7:0] n_pulse,
	output logic trigger_pin,
	output logic count_pin,
	output logic busy
);
	logic [15:0] left = '0;
	int ph = 0;
	// both pins idle high, as if pulled up; each count-pin level holds HALF cycles
	initial trigger_pin = 1'b1;
	initial count_pin = 1'b1;
	assign busy = (left != 16'h0000);
	always @(posedge clk) begin
		trigger_pin <= trig_lvl;
		if (go && !busy) begin
			left <= {7'h00, n_pulse, 1'b0};
			ph <= 0;
		end else if (busy) begin
			if (ph == HALF - 1) begin
				ph <= 0;
				left <= left - 16'h0001;
				count_pin <= ~count_pin;
			end else begin
				ph <= ph + 1;
			end
		end
	end
endmodule // rctmr_pins

// file: verif/testbench.sv
// self-checking bench of the reload/capture timer
`timescale 1ns/100ps
module testbench;
	logic clk = 0, rst = 1, hsel = 0, hwrite = 0, trig = 1, go = 0, dsus = 0, dsen = 0;
	logic [31:0] haddr = '0, hwdata = '0, hrdata, rd;
	logic [1:0] htrans = '0;
	logic [2:0] hsize = '0;
	logic [7:0] npul = '0;
	logic hreadyout, hresp, irq, adc, tpin, cpin, pbusy;
	logic [15:0] v, w, e;
	logic [7:0] regs [7] = '{8'h00, 8'h04, 8'h08, 8'h10, 8'h18, 8'h1c, 8'h0c};
	int n_mismatch = 0, tests_run = 0, n_adc = 0;
	initial forever #50 clk = ~clk;
	rctmr_top dut (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .trigger_pin(tpin), .count_pin(cpin),
		.debug_suspend(dsus), .debug_suspend_enable(dsen), .irq(irq), .adc_trigger_out(adc));
	rctmr_pins pins (.clk(clk), .trig_lvl(trig), .go(go), .n_pulse(npul),
		.trigger_pin(tpin), .count_pin(cpin), .busy(pbusy));
	// adc pulses are counted so a test can see whether any came
	always @(posedge clk) if (adc === 1'b1) n_adc <= n_adc + 1;
	task complete_run;
		$display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	task chk(input logic [31:0] g, input logic [31:0] x);
		tests_run++;
		if (g !== x) begin
			n_mismatch++;
			$display("[ERR] %0t got %h expected %h", $time, g, x);
		end
	endtask
	// bounded wait for an edge with hready high; a hang closes the run
	task wait_rdy;
		int i;
		i = 0;
		do begin
			@(posedge clk);
			i++;
		end while (hreadyout !== 1'b1 && i < 50);
		if (i >= 50) begin
			n_mismatch++;
			$display("[ERR] %0t bus hang", $time);
			complete_run;
		end
	endtask
	task bus(input logic wr_n, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= {24'h00_0000, a};
		htrans <= rctmr_pkg::HTRANS_NONSEQ;
		hwrite <= wr_n;
		hsize <= rctmr_pkg::HSIZE_WORD;
		wait_rdy;
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		wait_rdy;
		rd = hrdata;
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask
	task rc(input logic [7:0] a, input logic [31:0] x);
		bus(1'b0, a, 32'h0000_0000);
		chk(rd, x);
		chk({31'h0000_0000, hresp}, 32'h0000_0000);
	endtask
	task edge_to(input logic l);
		trig <= l;
		repeat (4) @(posedge clk);
	endtask
	// expected count after 240 cycles of running for prescale code c, 8 = fixed path
	function automatic logic [15:0] ticks(input int c);
		return (c < 8) ? 16'(240 >> c) : 16'h0014;
	endfunction
	initial begin
		void'($urandom(34808));
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		foreach (regs[i]) rc(regs[i], 32'h0000_0000);
		wr(8'h04, 32'hffff_ffff);
		rc(8'h04, 32'h0000_00ff);
		wr(8'h00, 32'hffff_fffb);
		rc(8'h00, 32'h0000_000b);
		wr(8'h1c, 32'hffff_ffff);
		rc(8'h1c, 32'h0000_0003);
		wr(8'h18, 32'h0000_00c0);
		rc(8'h18, 32'h0000_0000);
		v = 16'($urandom_range(16'h7fff));
		w = 16'($urandom);
		wr(8'h08, {16'h0000, v});
		rc(8'h08, {16'h0000, v});
		wr(8'h00, 32'h0000_0000);
		wr(8'h10, {16'h0000, w});
		rc(8'h10, {16'h0000, w});
		$display("test registers done");
		// overflow at div 1 reloads, flags, interrupts and fires the adc pulse
		wr(8'h04, 32'h0000_0010);
		// two ticks reach the wrap, two more run past the reload value
		wr(8'h10, 32'h0000_fffe);
		wr(8'h00, 32'h0000_0004);
		repeat (2) @(posedge clk);
		wr(8'h00, 32'h0000_0000);
		rc(8'h00, 32'h0000_0080);
		chk(irq, 1'b1);
		chk(n_adc > 0, 1'b1);
		bus(1'b0, 8'h10, 32'h0);
		chk(rd[15:0] - v < 16'h0008, 1'b1);
		wr(8'h18, 32'h0000_0040);
		rc(8'h00, 32'h0000_0080);
		wr(8'h18, 32'h0000_0080);
		rc(8'h00, 32'h0000_0000);
		chk(irq, 1'b0);
		$display("test overflow done");
		// trigger reload on the falling edge, then with events off
		wr(8'h04, 32'h0000_0000);
		wr(8'h00, 32'h0000_0008);
		wr(8'h1c, 32'h0000_0001);
		edge_to(1'b0);
		rc(8'h10, {16'h0000, v});
		rc(8'h00, 32'h0000_0048);
		chk(irq, 1'b1);
		edge_to(1'b1);
		wr(8'h18, 32'h0000_0040);
		rc(8'h00, 32'h0000_0008);
		wr(8'h00, 32'h0000_0000);
		wr(8'h10, {16'h0000, w});
		edge_to(1'b0);
		rc(8'h10, {16'h0000, w});
		rc(8'h00, 32'h0000_0000);
		edge_to(1'b1);
		$display("test reload done");
		// capture on rising edge only
		wr(8'h04, 32'h0000_0020);
		wr(8'h00, 32'h0000_0009);
		e = 16'($urandom);
		wr(8'h10, {16'h0000, e});
		edge_to(1'b0);
		rc(8'h08, {16'h0000, v});
		edge_to(1'b1);
		rc(8'h08, {16'h0000, e});
		wr(8'h00, 32'h0000_0000);
		wr(8'h18, 32'h0000_00c0);
		// hardware start on the rising edge only
		wr(8'h04, 32'h0000_00c0);
		edge_to(1'b0);
		rc(8'h00, 32'h0000_0000);
		edge_to(1'b1);
		bus(1'b0, 8'h00, 32'h0);
		chk(rd[2], 1'b1);
		wr(8'h00, 32'h0000_0000);
		$display("test capture and start done");
		// counter mode counts falling edges of the count pin
		wr(8'h04, 32'h0000_0000);
		wr(8'h10, 32'h0000_0000);
		wr(8'h00, 32'h0000_0006);
		npul <= 8'($urandom_range(20, 5));
		go <= 1'b1;
		@(posedge clk);
		go <= 1'b0;
		// the model turns busy only after the edge that saw go
		@(posedge clk);
		for (int i = 0; i < 500 && pbusy !== 1'b0; i++) @(posedge clk);
		if (pbusy !== 1'b0) begin
			n_mismatch++;
			$display("[ERR] %0t pulse burst hang", $time);
			complete_run;
		end
		rc(8'h10, {24'h00_0000, npul});
		// suspend freezes the count only while enabled
		wr(8'h04, 32'h0000_0010);
		wr(8'h10, 32'h0000_0100);
		dsus <= 1'b1;
		dsen <= 1'b1;
		wr(8'h00, 32'h0000_0004);
		repeat (20) @(posedge clk);
		rc(8'h10, 32'h0000_0100);
		dsen <= 1'b0;
		repeat (4) @(posedge clk);
		bus(1'b0, 8'h10, 32'h0);
		chk(rd[15:0] != 16'h0100, 1'b1);
		dsus <= 1'b0;
		$display("test counter and suspend done");
		// every prescale code, then the fixed divide-by-12 path
		for (int c = 0; c < 9; c++) begin
			wr(8'h04, (c < 8) ? 32'(16 + 2 * c) : 32'h0000_0000);
			wr(8'h10, 32'h0000_0000);
			wr(8'h00, 32'h0000_0004);
			repeat (238) @(posedge clk);
			wr(8'h00, 32'h0000_0000);
			bus(1'b0, 8'h10, 32'h0);
			chk(rd[15:0] - ticks(c) + 16'h0003 < 16'h0007, 1'b1);
		end
		$display("test prescaler done");
		// down count at div 1: 14 to 10 in four ticks, wrap to all ones, five more
		wr(8'h04, 32'h0000_0011);
		wr(8'h08, 32'h0000_0010);
		wr(8'h10, 32'h0000_0014);
		wr(8'h18, 32'h0000_00c0);
		wr(8'h1c, 32'h0000_0001);
		edge_to(1'b0);
		wr(8'h00, 32'h0000_0004);
		repeat (8) @(posedge clk);
		wr(8'h00, 32'h0000_0000);
		rc(8'h10, 32'h0000_fffa);
		rc(8'h00, 32'h0000_00c0);
		chk(irq, 1'b0);
		$display("test up/down done");
		complete_run;
	end
endmodule // testbench
